// *** core/eev_ctrl.sv ***
/*
 Edge event interrupt controller: nineteen edge-detecting lines, sixteen of
 them chosen from eighty pins, with pending, mask, interrupt and event outputs.
 Assumes pins are synchronous to pclk and the APB master follows the protocol.
*/
`timescale 1ns/1ps
`default_nettype none

module eev_ctrl
   import eev_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [EEV_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [EEV_PINS-1:0] pin_in,
   input wire logic [EEV_LINES-EEV_EXT_LINES-1:0] int_src,
   output logic [EEV_LINES-1:0] line_irq,
   output logic [EEV_LINES-1:0] line_event,
   output logic irq
);
   eev_apb_req_s req;
   logic [EEV_LINES-1:0] rise_en_ff, fall_en_ff, mask_ff, evmask_ff, pend_ff;
   logic [EEV_LINES-1:0] src, src_q_ff, rise_cap, fall_cap, trig, clr, nxt_pend;
   logic [EEV_SEL_W-1:0] sel_ff [EEV_EXT_LINES];
   logic [31:0] rdata;
   logic wr_acc, rd_acc, unmapped;
   logic [EEV_ADDR_W-1:0] sel_idx;

   assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};
   assign wr_acc = req.sel && req.en && req.wr;
   assign rd_acc = req.sel && req.en && !req.wr;
   assign sel_idx = EEV_ADDR_W'((req.addr - EEV_OFF_SEL0) >> 2);

   genvar g;
   generate
      for (g = 0; g < EEV_LINES; g++) begin : g_line
         if (g < EEV_EXT_LINES) begin : g_ext
            assign src[g] = (sel_ff[g] < EEV_SEL_W'(EEV_PINS)) ? pin_in[sel_ff[g]] : 1'b0;
         end else begin : g_int
            assign src[g] = int_src[g-EEV_EXT_LINES];
         end
         // one-cycle pulse capture
         // inputs are synchronous, so one clock is the narrowest pulse seen
         assign rise_cap[g] = src[g] && !src_q_ff[g];
         assign fall_cap[g] = !src[g] && src_q_ff[g];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q_ff <= '0;
      end else begin
         src_q_ff <= src;
      end
   end

   assign trig = (rise_cap & rise_en_ff) | (fall_cap & fall_en_ff);

   assign clr = (wr_acc && req.addr == EEV_OFF_PEND) ? req.wdata[EEV_LINES-1:0] : '0;
   // sticky pending, set wins over clear
   assign nxt_pend = (pend_ff & ~clr) | trig;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff <= '0;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rise_en_ff <= '0;
         fall_en_ff <= '0;
         mask_ff <= EEV_RST_MASK;
         evmask_ff <= EEV_RST_MASK;
      end else if (wr_acc) begin
         unique case (req.addr)
            EEV_OFF_RISE: rise_en_ff <= req.wdata[EEV_LINES-1:0];
            EEV_OFF_FALL: fall_en_ff <= req.wdata[EEV_LINES-1:0];
            EEV_OFF_MASK: mask_ff <= req.wdata[EEV_LINES-1:0];
            EEV_OFF_EVMASK: evmask_ff <= req.wdata[EEV_LINES-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < EEV_EXT_LINES; i++) sel_ff[i] <= EEV_RST_SEL;
      end else if (wr_acc && req.addr >= EEV_OFF_SEL0 && req.addr <= EEV_OFF_SEL_LAST
                   && req.addr[1:0] == 2'b00) begin
         sel_ff[sel_idx[3:0]] <= req.wdata[EEV_SEL_W-1:0];
      end
   end

   always_comb begin
      rdata = 32'h00000000;
      unmapped = 1'b0;
      if (req.addr >= EEV_OFF_SEL0 && req.addr <= EEV_OFF_SEL_LAST && req.addr[1:0] == 2'b00) begin
         rdata[EEV_SEL_W-1:0] = sel_ff[sel_idx[3:0]];
      end else begin
         unique case (req.addr)
            EEV_OFF_RISE: rdata[EEV_LINES-1:0] = rise_en_ff;
            EEV_OFF_FALL: rdata[EEV_LINES-1:0] = fall_en_ff;
            EEV_OFF_MASK: rdata[EEV_LINES-1:0] = mask_ff;
            EEV_OFF_PEND: rdata[EEV_LINES-1:0] = pend_ff;
            EEV_OFF_EVMASK: rdata[EEV_LINES-1:0] = evmask_ff;
            EEV_OFF_RAW: rdata[EEV_LINES-1:0] = src;
            default: unmapped = 1'b1;
         endcase
      end
   end

   // zero-wait slave: pready is registered so answer lands one cycle into access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= req.sel && !req.en;
         prdata <= (req.sel && !req.en && !req.wr) ? rdata : prdata;
         pslverr <= req.sel && !req.en && unmapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_irq <= '0;
         line_event <= '0;
         irq <= 1'b0;
      end else begin
         line_irq <= nxt_pend & mask_ff;
         line_event <= trig & evmask_ff;
         irq <= |(nxt_pend & mask_ff);
      end
   end

   property p_pend_set;
      @(posedge pclk) disable iff (!presetn) trig[0] |=> pend_ff[0];
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("trigger did not set pending");

   property p_rise_only;
      @(posedge pclk) disable iff (!presetn)
         (fall_cap[1] && !fall_en_ff[1] && !pend_ff[1] && clr[1] == 1'b0) |=> !pend_ff[1];
   endproperty
   a_rise_only: assert property (p_rise_only) else $error("disabled edge set pending");

   property p_irq_mask;
      @(posedge pclk) disable iff (!presetn) (!mask_ff[2] && !$rose(mask_ff[2])) |=> !line_irq[2];
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked line raised request");

   property p_irq_follow;
      @(posedge pclk) disable iff (!presetn) (pend_ff[3] && mask_ff[3] && !clr[3]) |=> line_irq[3];
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("pending unmasked line has no request");

   property p_clear;
      @(posedge pclk) disable iff (!presetn) (clr[4] && !trig[4]) |=> !pend_ff[4];
   endproperty
   a_clear: assert property (p_clear) else $error("write one did not clear pending");

   property p_short_pulse;
      @(posedge pclk) disable iff (!presetn)
         (rise_cap[5] && rise_en_ff[5]) ##1 !src[5] |-> pend_ff[5];
   endproperty
   a_short_pulse: assert property (p_short_pulse) else $error("one-cycle pulse lost");

   property p_src_sel;
      @(posedge pclk) disable iff (!presetn) (sel_ff[6] < 7'h50) |-> src[6] == pin_in[sel_ff[6]];
   endproperty
   a_src_sel: assert property (p_src_sel) else $error("line source not the selected pin");

   property p_ready;
      @(posedge pclk) disable iff (!presetn) (psel && !penable) |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready not one-cycle");

   property p_irq_or;
      @(posedge pclk) disable iff (!presetn) irq == (|line_irq);
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("irq differs from the line requests");

   property p_rd_pend;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && !pwrite && paddr == EEV_OFF_PEND)
         |=> prdata == 32'($past(pend_ff));
   endproperty
   a_rd_pend: assert property (p_rd_pend) else $error("pending read not the pending bits");

   property p_err_ready;
      @(posedge pclk) disable iff (!presetn) pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("error response without ready");

   property p_sel_wr;
      @(posedge pclk) disable iff (!presetn)
         (psel && penable && pwrite && paddr == EEV_OFF_SEL0 + 8'h0C)
         |=> sel_ff[3] == $past(pwdata[EEV_SEL_W-1:0]);
   endproperty
   a_sel_wr: assert property (p_sel_wr) else $error("selector write lost");

   property p_mask_wr;
      @(posedge pclk) disable iff (!presetn)
         (psel && penable && pwrite && paddr == EEV_OFF_MASK)
         |=> mask_ff == $past(pwdata[EEV_LINES-1:0]);
   endproperty
   a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

   // per-line checks, judged from src and the bus, with the trig strobe used by the w1c and event checks
   generate
      for (g = 0; g < EEV_LINES; g++) begin : g_chk
         property p_rise_seen;
            @(posedge pclk) disable iff (!presetn) (rise_en_ff[g] && $rose(src[g])) |=> pend_ff[g];
         endproperty
         a_rise_seen: assert property (p_rise_seen) else $error("enabled rising edge missed");

         property p_fall_seen;
            @(posedge pclk) disable iff (!presetn) (fall_en_ff[g] && $fell(src[g])) |=> pend_ff[g];
         endproperty
         a_fall_seen: assert property (p_fall_seen) else $error("enabled falling edge missed");

         property p_no_edge;
            @(posedge pclk) disable iff (!presetn)
               (!pend_ff[g] && !(rise_en_ff[g] && $rose(src[g])) && !(fall_en_ff[g] && $fell(src[g])))
               |=> !pend_ff[g];
         endproperty
         a_no_edge: assert property (p_no_edge) else $error("pending set with no enabled edge");

         property p_sticky;
            @(posedge pclk) disable iff (!presetn)
               (pend_ff[g] && !(psel && penable && pwrite && paddr == EEV_OFF_PEND && pwdata[g]))
               |=> pend_ff[g];
         endproperty
         a_sticky: assert property (p_sticky) else $error("pending dropped without a clear");

         property p_w1c;
            @(posedge pclk) disable iff (!presetn)
               (psel && penable && pwrite && paddr == EEV_OFF_PEND && pwdata[g] && !trig[g])
               |=> !pend_ff[g];
         endproperty
         a_w1c: assert property (p_w1c) else $error("write one left pending set");

         property p_masked;
            @(posedge pclk) disable iff (!presetn) !mask_ff[g] |=> !line_irq[g];
         endproperty
         a_masked: assert property (p_masked) else $error("masked line raised a request");

         property p_unmasked;
            @(posedge pclk) disable iff (!presetn)
               (pend_ff[g] && mask_ff[g] && !(psel && penable && pwrite && paddr == EEV_OFF_PEND && pwdata[g]))
               |=> line_irq[g];
         endproperty
         a_unmasked: assert property (p_unmasked) else $error("pending unmasked line has no request");

         property p_event_on;
            @(posedge pclk) disable iff (!presetn) (trig[g] && evmask_ff[g]) |=> line_event[g];
         endproperty
         a_event_on: assert property (p_event_on) else $error("enabled event not raised");

         property p_event_off;
            @(posedge pclk) disable iff (!presetn) !(trig[g] && evmask_ff[g]) |=> !line_event[g];
         endproperty
         a_event_off: assert property (p_event_off) else $error("event raised with no trigger");

         if (g < EEV_EXT_LINES) begin : g_src
            property p_src_pin;
               @(posedge pclk) disable iff (!presetn)
                  (sel_ff[g] < EEV_SEL_W'(EEV_PINS)) |-> src[g] == pin_in[sel_ff[g]];
            endproperty
            a_src_pin: assert property (p_src_pin) else $error("line source not the selected pin");

            property p_src_off;
               @(posedge pclk) disable iff (!presetn) (sel_ff[g] >= EEV_SEL_W'(EEV_PINS)) |-> !src[g];
            endproperty
            a_src_off: assert property (p_src_off) else $error("selector past the pins not quiet");
         end
      end
   endgenerate

   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   c_event: cover property (@(posedge pclk) disable iff (!presetn) |line_event);
   c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
   c_clear: cover property (@(posedge pclk) disable iff (!presetn) $fell(pend_ff[0]));
   c_both: cover property (@(posedge pclk) disable iff (!presetn) trig[0] && rise_en_ff[0] && fall_en_ff[0]);
endmodule

`default_nettype wire

// *** core/eev_pkg.sv ***
/*
 Package for the edge event interrupt controller: register offsets,
 field layout, reset values and shared types.
 Assumes an APB slave with 32-bit data and one aligned word per register.
*/
package eev_pkg;
   localparam int EEV_LINES = 19;
   localparam int EEV_EXT_LINES = 16;
   localparam int EEV_PINS = 80;
   localparam int EEV_SEL_W = 7;
   localparam int EEV_ADDR_W = 8;

   localparam logic [7:0] EEV_OFF_RISE = 8'h00;
   localparam logic [7:0] EEV_OFF_FALL = 8'h04;
   localparam logic [7:0] EEV_OFF_MASK = 8'h08;
   localparam logic [7:0] EEV_OFF_PEND = 8'h0C;
   localparam logic [7:0] EEV_OFF_EVMASK = 8'h10;
   localparam logic [7:0] EEV_OFF_RAW = 8'h14;
   localparam logic [7:0] EEV_OFF_SEL0 = 8'h20;
   localparam logic [7:0] EEV_OFF_SEL_LAST = 8'h5C;

   localparam logic [18:0] EEV_RST_MASK = 19'h00000;
   localparam logic [6:0] EEV_RST_SEL = 7'h00;

   typedef struct packed {
      logic sel;
      logic en;
      logic wr;
      logic [EEV_ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } eev_apb_req_s;
endpackage

// *** tb/eev_pin_model.sv ***
/* pin and on-chip event source model for the edge event controller
   assumes the bench moves one level at a time through drive() */
`timescale 1ns/1ps
`default_nettype none
module eev_pin_model
   import eev_pkg::*;
(
   input wire logic pclk,
   output logic [EEV_PINS-1:0] pin_in,
   output logic [EEV_LINES-EEV_EXT_LINES-1:0] int_src
);
   initial begin
      pin_in = '0;
      int_src = '0;
   end
   // indices past the pins reach the on-chip sources
   task automatic drive(input int idx, input logic val);
      @(posedge pclk);
      if (idx < EEV_PINS) pin_in[idx] <= val;
      else int_src[idx-EEV_PINS] <= val;
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/* self-checking bench for the edge event controller
   assumes eev_pin_model stands in for pins and sources */
`timescale 1ns/1ps
`default_nettype none
module testbench
   import eev_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, perr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [79:0] pin_in;
   logic [2:0] int_src;
   logic [18:0] line_irq, line_event, ev_seen;
   int error_cnt, n_tests, cyc;
   eev_ctrl i_eev_ctrl(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .int_src(int_src), .line_irq(line_irq), .line_event(line_event), .irq(irq));
   eev_pin_model i_eev_pin_model(.pclk(pclk), .pin_in(pin_in), .int_src(int_src));
   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      ev_seen <= presetn ? (ev_seen | line_event) : '0;
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // request held until pready is seen at a rising edge
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(0, a, 0);
      chk(rd, exp);
   endtask
   task automatic t_reset();
      rdc(EEV_OFF_MASK, 32'(EEV_RST_MASK));
      rdc(EEV_OFF_PEND, 0);
      rdc(EEV_OFF_SEL0, 32'(EEV_RST_SEL));
      chk(32'(irq), 0);
      $display("reset values done");
   endtask
   task automatic t_rise();
      apb(1, EEV_OFF_SEL0 + 8'h0C, 32'h4F);
      apb(1, EEV_OFF_RISE, 32'h8);
      apb(1, EEV_OFF_MASK, 32'h8);
      i_eev_pin_model.drive(79, 1);
      repeat (3) @(posedge pclk);
      rdc(EEV_OFF_PEND, 32'h8);
      rdc(EEV_OFF_RAW, 32'h8);
      chk(32'(line_irq), 32'h8);
      chk(32'(irq), 1);
      apb(1, EEV_OFF_PEND, 32'h8);
      i_eev_pin_model.drive(79, 0);
      repeat (3) @(posedge pclk);
      rdc(EEV_OFF_PEND, 0);
      chk(32'(irq), 0);
      $display("rising edge line done");
   endtask
   task automatic t_both();
      apb(1, EEV_OFF_RISE, 32'h20000);
      apb(1, EEV_OFF_FALL, 32'h20000);
      apb(1, EEV_OFF_EVMASK, 32'h20000);
      i_eev_pin_model.drive(81, 1);
      repeat (3) @(posedge pclk);
      rdc(EEV_OFF_PEND, 32'h20000);
      apb(1, EEV_OFF_PEND, 32'h20000);
      i_eev_pin_model.drive(81, 0);
      repeat (3) @(posedge pclk);
      rdc(EEV_OFF_PEND, 32'h20000);
      chk(32'(line_irq), 0);
      chk(32'(irq), 0);
      chk(32'(ev_seen), 32'h20000);
      $display("both edges masked line done");
   endtask
   task automatic t_err();
      apb(1, 8'h60, 32'h1);
      chk(32'(perr), 1);
      rdc(8'h60, 0);
      chk(32'(perr), 1);
      $display("unmapped access done");
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      presetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_rise();
      t_both();
      t_err();
      tally_and_finish();
   end
endmodule
`default_nettype wire
